/* dsrp_pkg.sv */
// dsrp_pkg: constants and types for the dual serial register port.
// assumes a 25 MHz system clock and a master-driven serial clock pin.
package dsrp_pkg;

	// register side widths
	localparam int DSRP_AW = 7;
	localparam int DSRP_DW = 8;
	localparam int DSRP_SPI_AW = 6;

	// fixed two-wire slave address and the high-speed master code prefix
	localparam logic [6:0] DSRP_SLAVE_ADDR = 7'h5F;
	localparam logic [4:0] DSRP_HS_PREFIX = 5'h01;

	// bit counts of one byte and of the three-wire command header
	localparam logic [3:0] DSRP_BYTE_BITS = 4'h8;
	localparam logic [3:0] DSRP_HDR_LAST = 4'h7;
	localparam logic [2:0] DSRP_BIT_LAST = 3'h7;

	// clock figures: fast-mode ceiling and the system clock
	localparam int DSRP_CLK_KHZ = 25000;
	localparam int DSRP_FAST_KHZ = 400;
	// shortest half period of a fast-mode clock, in system cycles
	localparam int DSRP_HALF_CYC = DSRP_CLK_KHZ / (2 * DSRP_FAST_KHZ);
	// a pin change is seen this many cycles late
	localparam int DSRP_SYNC_LAT = 3;

	// synchroniser lanes and their idle levels
	localparam int DSRP_NSYNC = 5;
	localparam int DSRP_S_SCL = 0;
	localparam int DSRP_S_SDA = 1;
	localparam int DSRP_S_CS = 2;
	localparam int DSRP_S_WT = 3;
	localparam int DSRP_S_RT = 4;
	localparam logic [4:0] DSRP_SYNC_IDLE = 5'h07;

	// two-wire slave states, gray coded along the write path
	typedef enum logic [3:0] {
		DSRP_IDLE     = 4'h0,
		DSRP_ADDR     = 4'h1,
		DSRP_ADDR_ACK = 4'h3,
		DSRP_SUB      = 4'h2,
		DSRP_SUB_ACK  = 4'h6,
		DSRP_WDATA    = 4'h7,
		DSRP_WDAT_ACK = 4'h5,
		DSRP_RDATA    = 4'h4,
		DSRP_RDAT_ACK = 4'hC
	} dsrp_state_t;

endpackage

/* dsrp_serial_port.sv */
// dsrp_serial_port: slave serial access to an 8-bit register space,
// two-wire mode with the select pin high, three-wire mode with it low.
// assumes the register space answers a read on the edge after reg_rd
// and that the serial clock pin is driven by the external master.
`timescale 1ns/1ps

// Notes on behaviour
// - select high picks two-wire, low three-wire
// - two-wire works up to 400 kHz
// - start and stop from data edges
// - address 1011111 matched, eighth bit direction
// - acknowledge low through clock high
// - pointer byte: index plus step bit
// - write: address, pointer, data, each acknowledged
// - read after repeated start, nack ends
// - eight bits per byte, MSB first
// - slave holds clock low while fetching a read byte
// - no match leaves data line high
// - high-speed master code never acknowledged
// - high-speed mode held until stop
// - three-wire modes 0 and 3
// - launch on falling, sample on rising
// - sixteen clocks, eight more per byte
// - first command bit: 1 read, 0 write
// - second command bit steps the index
// - six-bit index, then write payload bytes
// - read payload MSB first, multi-byte
module dsrp_serial_port (
	// system side
	input  wire logic                        clk,
	input  wire logic                        rst,
	// shared pins
	input  wire logic                        serial_port_clock,
	input  wire logic                        cs_pin,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	output logic                             scl_out,
	output logic                             scl_oe,
	// register space access
	output logic [dsrp_pkg::DSRP_AW-1:0]     reg_addr,
	output logic [dsrp_pkg::DSRP_DW-1:0]     reg_wdata,
	output logic                             reg_wr,
	output logic                             reg_rd,
	input  wire logic [dsrp_pkg::DSRP_DW-1:0] reg_rdata,
	// bus state
	output logic                             i2c_busy,
	output logic                             hs_mode
);
	import dsrp_pkg::*;

	// ---- clk domain signals
	logic [DSRP_NSYNC-1:0] s1_reg;
	logic [DSRP_NSYNC-1:0] s2_reg;
	logic [DSRP_NSYNC-1:0] s3_reg;
	logic [DSRP_NSYNC-1:0] f_reg;
	logic [DSRP_NSYNC-1:0] fd_reg;
	logic [DSRP_NSYNC-1:0] agree;
	logic                  i2c_en;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;
	dsrp_state_t           state_reg;
	logic [7:0]            sh_reg;
	logic [3:0]            cnt_reg;
	logic                  rw_reg;
	logic                  mack_reg;
	logic                  first_reg;
	logic [DSRP_AW-1:0]    ptr_reg;
	logic                  step_reg;
	logic [DSRP_AW-1:0]    acc_addr_reg;
	logic [DSRP_DW-1:0]    acc_data_reg;
	logic                  i2c_wr_reg;
	logic                  i2c_rd_reg;
	logic                  pend_reg;
	logic                  i2c_oe_reg;
	logic                  rd_valid_reg;
	logic                  rd_done_reg;
	logic [DSRP_DW-1:0]    rd_word_reg;
	logic                  wt_seen_reg;
	logic                  rt_seen_reg;
	logic                  spi_wr_ev;
	logic                  spi_rd_ev;

	// ---- link domain signals
	logic [3:0]             hcnt_reg;
	logic [2:0]             bcnt_reg;
	logic [7:0]             sin_reg;
	logic                   srw_reg;
	logic                   sstep_reg;
	logic [DSRP_SPI_AW-1:0] saddr_reg;
	logic [DSRP_SPI_AW-1:0] req_addr_reg;
	logic [DSRP_DW-1:0]     req_data_reg;
	logic                   wt_reg;
	logic                   rt_reg;
	logic [DSRP_SPI_AW-1:0] saddr_next;
	logic [7:0]             sbyte;
	logic [7:0]             sout_reg;
	logic                   soe_reg;

	// ==== pin and toggle synchronisers, three stages each
	// fast mode
	// three cycles of latency stays far below one fast-mode half period
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= DSRP_SYNC_IDLE;
			s2_reg <= DSRP_SYNC_IDLE;
			s3_reg <= DSRP_SYNC_IDLE;
		end else begin
			s1_reg <= {rt_reg, wt_reg, cs_pin, sda_in, serial_port_clock};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a lane changes only once the second and third stages agree
	assign agree = ~(s2_reg ^ s3_reg);

	// filtered levels and their previous values for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			f_reg  <= DSRP_SYNC_IDLE;
			fd_reg <= DSRP_SYNC_IDLE;
		end else begin
			f_reg  <= (s3_reg & agree) | (f_reg & ~agree);
			fd_reg <= f_reg;
		end
	end

	assign i2c_en = f_reg[DSRP_S_CS];
	assign scl_rise = f_reg[DSRP_S_SCL] & ~fd_reg[DSRP_S_SCL];
	assign scl_fall = ~f_reg[DSRP_S_SCL] & fd_reg[DSRP_S_SCL];

	assign start_det = i2c_en & f_reg[DSRP_S_SCL] & fd_reg[DSRP_S_SCL]
		& fd_reg[DSRP_S_SDA] & ~f_reg[DSRP_S_SDA];
	assign stop_det = i2c_en & f_reg[DSRP_S_SCL] & fd_reg[DSRP_S_SCL]
		& ~fd_reg[DSRP_S_SDA] & f_reg[DSRP_S_SDA];

	// ==== bus busy and high-speed tracking
	always_ff @(posedge clk) begin
		if (rst || !i2c_en) begin
			i2c_busy <= 1'b0;
		end else if (start_det) begin
			i2c_busy <= 1'b1;
		end else if (stop_det) begin
			i2c_busy <= 1'b0;
		end
	end

	// high-speed hold
	// a master code sets the mode; repeated starts keep it, stop ends it
	always_ff @(posedge clk) begin
		if (rst || !i2c_en || stop_det) begin
			hs_mode <= 1'b0;
		end else if (state_reg == DSRP_ADDR && first_reg && scl_fall
			&& cnt_reg == DSRP_BYTE_BITS && sh_reg[7:3] == DSRP_HS_PREFIX) begin
			hs_mode <= 1'b1;
		end
	end

	// ==== two-wire slave engine
	always_ff @(posedge clk) begin
		if (rst || !i2c_en) begin
			state_reg    <= DSRP_IDLE;
			sh_reg       <= '0;
			cnt_reg      <= '0;
			rw_reg       <= 1'b0;
			mack_reg     <= 1'b0;
			first_reg    <= 1'b1;
			ptr_reg      <= '0;
			step_reg     <= 1'b0;
			acc_addr_reg <= '0;
			acc_data_reg <= '0;
			i2c_wr_reg   <= 1'b0;
			i2c_rd_reg   <= 1'b0;
			pend_reg     <= 1'b0;
			i2c_oe_reg   <= 1'b0;
		end else begin
			i2c_wr_reg <= 1'b0;
			i2c_rd_reg <= 1'b0;
			if (start_det) begin
				// first start after stop versus a repeated start
				first_reg  <= !i2c_busy;
				state_reg  <= DSRP_ADDR;
				cnt_reg    <= '0;
				pend_reg   <= 1'b0;
				i2c_oe_reg <= 1'b0;
			end else if (stop_det) begin
				state_reg  <= DSRP_IDLE;
				pend_reg   <= 1'b0;
				i2c_oe_reg <= 1'b0;
			end else if (pend_reg) begin
				// clock stretch
				// clock is held low until the fetched byte is in
				if (rd_done_reg) begin
					sh_reg     <= rd_word_reg;
					i2c_oe_reg <= ~rd_word_reg[7];
					cnt_reg    <= 4'h1;
					pend_reg   <= 1'b0;
				end
			end else begin
				case (state_reg)
				DSRP_ADDR, DSRP_SUB, DSRP_WDATA: begin
					if (scl_rise && cnt_reg != DSRP_BYTE_BITS) begin
						sh_reg  <= {sh_reg[6:0], f_reg[DSRP_S_SDA]};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == DSRP_BYTE_BITS) begin
						cnt_reg <= '0;
						if (state_reg == DSRP_ADDR) begin
							if (sh_reg[7:1] == DSRP_SLAVE_ADDR) begin
								rw_reg     <= sh_reg[0];
								i2c_oe_reg <= 1'b1;
								state_reg  <= DSRP_ADDR_ACK;
							end else begin
								state_reg <= DSRP_IDLE;
							end
						end else if (state_reg == DSRP_SUB) begin
							ptr_reg    <= sh_reg[6:0];
							step_reg   <= sh_reg[7];
							i2c_oe_reg <= 1'b1;
							state_reg  <= DSRP_SUB_ACK;
						end else begin
							acc_addr_reg <= ptr_reg;
							acc_data_reg <= sh_reg;
							i2c_wr_reg   <= 1'b1;
							ptr_reg      <= ptr_reg + DSRP_AW'(step_reg);
							i2c_oe_reg   <= 1'b1;
							state_reg    <= DSRP_WDAT_ACK;
						end
					end
				end
				// acknowledge slot
				// low is held from this fall through the next whole high
				DSRP_ADDR_ACK, DSRP_SUB_ACK, DSRP_WDAT_ACK: begin
					if (scl_fall) begin
						i2c_oe_reg <= 1'b0;
						if (state_reg == DSRP_ADDR_ACK && rw_reg) begin
							acc_addr_reg <= ptr_reg;
							i2c_rd_reg   <= 1'b1;
							ptr_reg      <= ptr_reg + DSRP_AW'(step_reg);
							pend_reg     <= 1'b1;
							state_reg    <= DSRP_RDATA;
						end else if (state_reg == DSRP_ADDR_ACK) begin
							state_reg <= DSRP_SUB;
						end else begin
							state_reg <= DSRP_WDATA;
						end
					end
				end
				DSRP_RDATA: begin
					if (scl_fall) begin
						if (cnt_reg == DSRP_BYTE_BITS) begin
							// release for the master's answer
							i2c_oe_reg <= 1'b0;
							state_reg  <= DSRP_RDAT_ACK;
						end else begin
							i2c_oe_reg <= ~sh_reg[6];
							sh_reg     <= {sh_reg[6:0], 1'b0};
							cnt_reg    <= cnt_reg + 4'h1;
						end
					end
				end
				DSRP_RDAT_ACK: begin
					if (scl_rise) begin
						mack_reg <= ~f_reg[DSRP_S_SDA];
					end else if (scl_fall) begin
						if (mack_reg) begin
							acc_addr_reg <= ptr_reg;
							i2c_rd_reg   <= 1'b1;
							ptr_reg      <= ptr_reg + DSRP_AW'(step_reg);
							pend_reg     <= 1'b1;
							state_reg    <= DSRP_RDATA;
						end else begin
							state_reg <= DSRP_IDLE;
						end
					end
				end
				default: begin
					state_reg <= DSRP_IDLE;
				end
				endcase
			end
		end
	end

	// ==== three-wire requests seen in the clk domain
	// a toggle counts once filtered, so the request word is long settled
	assign spi_wr_ev = !i2c_en && (f_reg[DSRP_S_WT] != wt_seen_reg);
	assign spi_rd_ev = !i2c_en && (f_reg[DSRP_S_RT] != rt_seen_reg);

	always_ff @(posedge clk) begin
		if (rst) begin
			wt_seen_reg <= 1'b0;
			rt_seen_reg <= 1'b0;
		end else begin
			wt_seen_reg <= f_reg[DSRP_S_WT];
			rt_seen_reg <= f_reg[DSRP_S_RT];
		end
	end

	// ==== register space port, shared by both modes
	// only one mode is live at a time, so the two sources never collide
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_addr  <= '0;
			reg_wdata <= '0;
			reg_wr    <= 1'b0;
			reg_rd    <= 1'b0;
		end else begin
			reg_wr <= i2c_wr_reg | spi_wr_ev;
			reg_rd <= i2c_rd_reg | spi_rd_ev;
			if (i2c_wr_reg || i2c_rd_reg) begin
				reg_addr  <= acc_addr_reg;
				reg_wdata <= acc_data_reg;
			end else if (spi_wr_ev || spi_rd_ev) begin
				reg_addr  <= {1'b0, req_addr_reg};
				reg_wdata <= req_data_reg;
			end
		end
	end

	// read data returns the edge after reg_rd and is held for both modes
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_valid_reg <= 1'b0;
			rd_done_reg  <= 1'b0;
			rd_word_reg  <= '0;
		end else begin
			rd_valid_reg <= reg_rd;
			rd_done_reg  <= rd_valid_reg;
			if (rd_valid_reg) begin
				rd_word_reg <= reg_rdata;
			end
		end
	end

	// ==== three-wire engine, rising edges of the link clock
	// select frames
	// select high clears the frame; no edge is counted on outside it
	assign sbyte = {sin_reg[6:0], sda_in};
	assign saddr_next = saddr_reg + DSRP_SPI_AW'(sstep_reg);

	always_ff @(posedge serial_port_clock or posedge cs_pin) begin
		if (cs_pin) begin
			hcnt_reg  <= '0;
			bcnt_reg  <= '0;
			sin_reg   <= '0;
			srw_reg   <= 1'b0;
			sstep_reg <= 1'b0;
			saddr_reg <= '0;
		end else begin
			sin_reg <= sbyte;
			if (hcnt_reg != DSRP_BYTE_BITS) begin
				hcnt_reg <= hcnt_reg + 4'h1;
				if (hcnt_reg == DSRP_HDR_LAST) begin
					srw_reg   <= sbyte[7];
					sstep_reg <= sbyte[6];
					saddr_reg <= sbyte[5:0];
				end
			end else begin
				bcnt_reg <= bcnt_reg + 3'h1;
				if (bcnt_reg == DSRP_BIT_LAST) begin
					saddr_reg <= saddr_next;
				end
			end
		end
	end

	// request words and toggles live across frames, so only rst clears them
	always_ff @(posedge serial_port_clock or posedge rst) begin
		if (rst) begin
			req_addr_reg <= '0;
			req_data_reg <= '0;
			wt_reg       <= 1'b0;
			rt_reg       <= 1'b0;
		end else if (!cs_pin) begin
			if (hcnt_reg == DSRP_HDR_LAST && sbyte[7]) begin
				req_addr_reg <= sbyte[5:0];
				rt_reg       <= ~rt_reg;
			end else if (hcnt_reg == DSRP_BYTE_BITS
				&& bcnt_reg == DSRP_BIT_LAST) begin
				if (srw_reg) begin
					req_addr_reg <= saddr_next;
					rt_reg       <= ~rt_reg;
				end else begin
					req_addr_reg <= saddr_reg;
					req_data_reg <= sbyte;
					wt_reg       <= ~wt_reg;
				end
			end
		end
	end

	// ==== three-wire read payload, falling edges of the link clock
	// modes 0 and 3
	// counting rises makes both idle levels line up the same
	// limitation: the fetched word must be settled before this fall
	always_ff @(negedge serial_port_clock or posedge cs_pin) begin
		if (cs_pin) begin
			sout_reg <= '0;
			soe_reg  <= 1'b0;
		end else if (srw_reg && hcnt_reg == DSRP_BYTE_BITS) begin
			soe_reg <= 1'b1;
			if (bcnt_reg == '0) begin
				sout_reg <= rd_word_reg;
			end else begin
				sout_reg <= {sout_reg[6:0], 1'b0};
			end
		end else begin
			soe_reg <= 1'b0;
		end
	end

	// ==== pin drivers
	// two-wire side only ever pulls low; three-wire drives both levels
	assign sda_out = soe_reg ? sout_reg[7] : 1'b0;
	assign sda_oe  = soe_reg | (i2c_oe_reg & i2c_en);
	assign scl_out = 1'b0;
	assign scl_oe  = pend_reg & i2c_en;

endmodule // dsrp_serial_port

/* dsrp_chk.sv */
// dsrp_chk: port-level assertions for the dual serial register port.
// assumes it is bound to the port module and sees resolved pin levels.
`timescale 1ns/1ps
module dsrp_chk (
	// system side
	input logic	clk,
	input logic	rst,
	// shared pins
	input logic	serial_port_clock,
	input logic	cs_pin,
	input logic	sda_in,
	input logic	sda_out,
	input logic	sda_oe,
	input logic	scl_out,
	input logic	scl_oe,
	// register space access
	input logic [dsrp_pkg::DSRP_AW-1:0]	reg_addr,
	input logic [dsrp_pkg::DSRP_DW-1:0]	reg_wdata,
	input logic	reg_wr,
	input logic	reg_rd,
	input logic [dsrp_pkg::DSRP_DW-1:0]	reg_rdata,
	// bus state
	input logic	i2c_busy,
	input logic	hs_mode
);
	import dsrp_pkg::*;

	// cycles since high-speed entry; the master code's ack slot falls inside
	logic [6:0]	hs_cnt_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			hs_cnt_reg <= 7'h00;
		end else if ($rose(hs_mode)) begin
			hs_cnt_reg <= 7'h01;
		end else if (hs_cnt_reg == 7'h64) begin
			hs_cnt_reg <= 7'h00;
		end else if (hs_cnt_reg != 7'h00) begin
			hs_cnt_reg <= hs_cnt_reg + 7'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// register port idle for two cycles after any access
	sequence quiet_s;
		(!reg_rd && !reg_wr) [*2];
	endsequence
	// fetch under stretch: read strobe, then the clock is let go
	sequence fetch_s;
		##[0:3] reg_rd ##[1:6] !scl_oe;
	endsequence

	mode_select_a: assert property ((!cs_pin) [*6] |-> !i2c_busy && !hs_mode)
		else $error("two-wire state alive in three-wire mode");
	open_drain_a: assert property (cs_pin && sda_oe |-> !sda_out)
		else $error("two-wire data driven high");
	ack_hold_a: assert property ((cs_pin && serial_port_clock && sda_oe) ##1 serial_port_clock
		|-> sda_oe)
		else $error("data released while clock high");
	data_stable_a: assert property ((cs_pin && serial_port_clock && !sda_oe) ##1 serial_port_clock
		|-> !sda_oe)
		else $error("data pulled while clock high");
	busy_drive_a: assert property (cs_pin && sda_oe |-> i2c_busy)
		else $error("data driven with bus free");
	hs_no_ack_a: assert property (hs_cnt_reg != 7'h00 |-> !sda_oe)
		else $error("master code acknowledged");
	hs_hold_a: assert property ($fell(hs_mode) |-> !i2c_busy)
		else $error("high speed left before stop");
	wr_space_a: assert property (reg_wr |=> quiet_s)
		else $error("register access too soon after write");
	rd_space_a: assert property (reg_rd |=> quiet_s)
		else $error("register access too soon after read");
	fetch_stretch_a: assert property ($rose(scl_oe) |-> fetch_s)
		else $error("clock stretch without fetch or release");
	spi_release_a: assert property ($rose(cs_pin) |-> !sda_oe)
		else $error("data line held after frame end");

endmodule // dsrp_chk

bind dsrp_serial_port dsrp_chk chk_i (.clk(clk), .rst(rst),
	.serial_port_clock(serial_port_clock), .cs_pin(cs_pin), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .i2c_busy(i2c_busy), .hs_mode(hs_mode));

/* dsrp_host_model.sv */
// dsrp_host_model: bus master on the shared pins, two-wire and three-wire.
// assumes the bench resolves the wires and runs clk at 25 MHz.
`timescale 1ns/1ps
module dsrp_host_model (
	// timing reference
	input logic	clk,
	// resolved wire levels
	input logic	scl_w,
	input logic	sda_w,
	// master drives, 1 releases the two-wire pins
	output logic	m_scl,
	output logic	m_sda,
	output logic	cs
);
	// half period in clk cycles, a little under 400 kHz
	localparam int HALF = 33;
	logic	clash;

	// idle: pins released, select high
	initial begin
		m_scl = 1'b1;
		m_sda = 1'b1;
		cs = 1'b1;
		clash = 1'b0;
	end

	task automatic start();
		m_sda = 1'b1;
		repeat (HALF) @(negedge clk);
		m_scl = 1'b1;
		repeat (HALF) @(negedge clk);
		m_sda = 1'b0;
		repeat (HALF) @(negedge clk);
		m_scl = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	task automatic stop();
		m_sda = 1'b0;
		repeat (HALF) @(negedge clk);
		m_scl = 1'b1;
		repeat (HALF) @(negedge clk);
		m_sda = 1'b1;
		repeat (HALF) @(negedge clk);
	endtask

	// one pulse, waits while the slave holds the clock low
	task automatic bit_io(input logic b, output logic s);
		int w;
		m_sda = b;
		repeat (HALF) @(negedge clk);
		m_scl = 1'b1;
		w = 0;
		while (scl_w !== 1'b1 && w < 2000) begin
			@(negedge clk);
			w++;
		end
		repeat (HALF) @(negedge clk);
		s = sda_w;
		m_scl = 1'b0;
		// data held a little past the fall so no false start is seen
		repeat (4) @(negedge clk);
	endtask

	// eight bits msb first, line released for the ack
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, ack);
	endtask

	// read a byte, then acknowledge or not
	task automatic rbyte(input logic nak, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(nak, s);
	endtask

	// framed by select, launch on fall, sample on rise
	task automatic spi(input logic m3, input logic [7:0] h, input int nb,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [23:0] tx;
		tx = {h, wd};
		rd = 16'h0000;
		// clock stays parked high until select is low; mode 0 then drops it
		@(negedge clk);
		cs = 1'b0;
		@(negedge clk);
		m_scl = m3;
		#17;
		for (int k = 0; k < 8 + 8 * nb; k++) begin
			if (k > 0 || m3) begin
				m_scl = 1'b0;
			end
			m_sda = (h[7] && k >= 8) ? 1'b1 : tx[23 - k];
			#6;
			if (!h[7] && sda_w !== m_sda) begin
				clash = 1'b1;
			end
			if (k >= 8) begin
				rd = {rd[14:0], sda_w};
			end
			m_scl = 1'b1;
			#6;
			// the slave's fetch and write-back need system cycles here
			if (k % 8 == 7) begin
				#500;
			end
		end
		@(negedge clk);
		cs = 1'b1;
		m_sda = 1'b1;
		m_scl = 1'b1;
	endtask

endmodule // dsrp_host_model

/* tb_top.sv */
// tb_top: self-checking bench for the dual serial register port.
// assumes the host model drives both link modes; register space lives here.
`timescale 1ns/1ps
module tb_top;
	import dsrp_pkg::*;

	logic	clk, rst, scl_w, sda_w, m_scl, m_sda, cs;
	logic	sda_out, sda_oe, scl_out, scl_oe, reg_wr, reg_rd, i2c_busy, hs_mode;
	logic [DSRP_AW-1:0]	reg_addr;
	logic [DSRP_DW-1:0]	reg_wdata, reg_rdata;
	logic [7:0]	mem [0:127];
	int	error_cnt = 0;
	int	num_checks = 0;

	// wire-and with the clock stretch; data pulled up when nobody drives
	assign scl_w = m_scl & (scl_oe ? scl_out : 1'b1);
	assign sda_w = sda_oe ? sda_out : m_sda;

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// register space: write on strobe, read data ready by the next edge
	always @(posedge clk) begin
		if (reg_wr) mem[reg_addr] <= reg_wdata;
		if (reg_rd) reg_rdata <= mem[reg_addr];
	end

	dsrp_serial_port dut (.clk(clk), .rst(rst), .serial_port_clock(scl_w), .cs_pin(cs),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
		.scl_oe(scl_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .i2c_busy(i2c_busy), .hs_mode(hs_mode));
	dsrp_host_model host (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .m_scl(m_scl),
		.m_sda(m_sda), .cs(cs));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wr_ack(input logic [7:0] b, input logic exp);
		logic a;
		host.wbyte(b, a);
		chk(16'(a), 16'(exp), "ack slot");
	endtask

	task automatic t_i2c_write();
		host.start();
		chk(16'(i2c_busy), 16'h0001, "busy after start");
		wr_ack(8'hBE, 1'b0);
		wr_ack(8'h85, 1'b0);
		wr_ack(8'hA1, 1'b0);
		wr_ack(8'hB2, 1'b0);
		host.stop();
		repeat (8) @(negedge clk);
		chk(16'(i2c_busy), 16'h0000, "busy after stop");
		chk(16'(mem[5]), 16'h00A1, "first byte");
		chk(16'(mem[6]), 16'h00B2, "stepped byte");
	endtask

	task automatic t_i2c_read();
		logic [7:0] d;
		host.start();
		wr_ack(8'hBE, 1'b0);
		wr_ack(8'h85, 1'b0);
		host.start();
		wr_ack(8'hBF, 1'b0);
		host.rbyte(1'b0, d);
		chk(16'(d), 16'h00A1, "read under stretch");
		host.rbyte(1'b1, d);
		chk(16'(d), 16'h00B2, "last read byte");
		host.stop();
		host.start();
		wr_ack(8'hBC, 1'b1);
		host.stop();
	endtask

	task automatic t_hs();
		for (int c = 0; c < 8; c++) begin
			host.start();
			wr_ack(8'h08 | 8'(c), 1'b1);
			chk(16'(hs_mode), 16'h0001, "code enters high speed");
			host.stop();
		end
		host.start();
		wr_ack(8'h0A, 1'b1);
		host.start();
		wr_ack(8'hBE, 1'b0);
		wr_ack(8'h10, 1'b0);
		wr_ack(8'h3C, 1'b0);
		host.start();
		chk(16'(hs_mode), 16'h0001, "held over repeated start");
		host.stop();
		repeat (8) @(negedge clk);
		chk(16'(hs_mode), 16'h0000, "left at stop");
		chk(16'(mem[16]), 16'h003C, "write in high speed");
	endtask

	task automatic t_spi();
		logic [15:0] r;
		host.spi(1'b1, 8'h43, 2, 16'h5A6B, r);
		host.spi(1'b1, 8'h07, 1, 16'hC700, r);
		repeat (12) @(negedge clk);
		chk(16'(mem[3]), 16'h005A, "three-wire write");
		chk(16'(mem[4]), 16'h006B, "stepped write");
		chk(16'(mem[7]), 16'h00C7, "single write");
		chk(16'(host.clash), 16'h0000, "line left to master");
		chk(16'(i2c_busy), 16'h0000, "two-wire idle");
		host.spi(1'b0, 8'hC3, 2, 16'h0000, r);
		repeat (2) @(negedge clk);
		chk(r, 16'h5A6B, "mode 0 stepped read");
		chk(16'(sda_oe), 16'h0000, "line released");
		host.spi(1'b1, 8'h83, 2, 16'h0000, r);
		chk(r, 16'h5A5A, "fixed index read");
		host.spi(1'b1, 8'h87, 1, 16'h0000, r);
		chk(r, 16'h00C7, "single read");
	endtask

	// main sequence: reset, then the two-wire and three-wire scenarios
	initial begin
		rst = 1'b1;
		reg_rdata = 8'h00;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		t_i2c_write();
		t_i2c_read();
		t_hs();
		t_spi();
		finish_test();
	end

	// watchdog: a few times the expected run length
	initial begin
		#3000000;
		error_cnt++;
		finish_test();
	end

endmodule // tb_top
